// file: blaf_line_adapter.sv
`include "blaf_defs.svh"
// What this block does
// [R1] one FF pad per change-of-direction character, after the block check if any
// [R2] FF is sent as second character of NAK and EOT
// [R3] every transmission starts with a 55 pad before the sync pattern
// [R4] receive drops leading and trailing pads, keeps the one after EOT or NAK
// [R5] transmitter sends two SYN; receiver syncs only on two consecutive SYN
// [R6] with internal bit timing two extra 55 bytes precede the sync pattern
// [R7] SYN SYN, or DLE SYN when transparent, at each transmit timeout, unchecked
// [R8] SYN SYN follows the block check after an intermediate-block character
// [R9] transmitter makes SYN, pad and block check; LRC in ASCII mode
// [R10] receiver removes SYN and block check characters before storing
// [R11] response characters come from the program and are stored unchanged
// [R12] op-end and block latches clear on their test read and on disable
// [R13] either latch sets sticky pending; disabled interrupts only mask the request
// [R14] op-end ends every operation and the timed wait, even when disabled
// [R15] auto-call ends only on connection or abandon
// [R16] receive ends on change of direction, stop address or timeout
// [R17] transmit ends when current, transition and stop addresses are equal
// [R18] adapter check during transmit ends the operation at once
// [R19] loop test ends when current address reaches stop address
// [R20] slave raises block latch on a clean intermediate-block character
// [R21] host must service a block latch before the next one arrives
// [R22] start command is F3 with device 1000 and a control byte
// [R23] current address steps by one on each storage cycle steal
module blaf_line_adapter #(
  parameter int unsigned TX_FILL_CYC = `BLAF_TX_FILL_MS * (`BLAF_CLK_HZ / 1000),
  parameter int unsigned WAIT_CYC = `BLAF_WAIT_MS * (`BLAF_CLK_HZ / 1000),
  parameter int unsigned RX_TMO_CYC = `BLAF_RX_TMO_MS * (`BLAF_CLK_HZ / 1000)
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // storage cycle steal
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  // synchronous line
  input wire logic line_clk,
  input wire logic rx_data,
  input wire logic adapter_check,
  output logic tx_data,
  // automatic calling unit
  output logic [3:0] acu_digit,
  output logic acu_strobe,
  input wire logic acu_connected,
  input wire logic acu_abandoned,
  // interrupt request
  output logic irq
);
  blaf_pkg::blaf_regs_type r;
  blaf_pkg::blaf_regs_type next_r;

  function automatic logic [15:0] bc_upd(input logic [15:0] bc, input logic [7:0] b,
                                         input logic asc);
    logic [15:0] c;
    c = bc ^ {8'h00, b};
    if (asc) begin
      c = {8'h00, bc[7:0] ^ b};
    end else begin
      for (int i = 0; i < 8; i++) begin
        c = c[0] ? ((c >> 1) ^ `BLAF_CRC_POLY) : (c >> 1);
      end
    end
    return c;
  endfunction

  always_comb begin
    blaf_pkg::blaf_regs_type n;
    logic [7:0] b;
    logic [7:0] ctl;
    logic [2:0] nc;
    logic [15:0] c_bc;
    logic c_on;
    logic c_xpar;
    logic blk;
    logic cod;
    logic lrise;
    logic lfall;
    logic din;
    logic mism;
    logic fin;
    logic [7:0] nsh;
    n = r;
    b = 8'h00;
    ctl = 8'h00;
    nc = 3'h0;
    mism = 1'b0;
    fin = 1'b0;
    n.rb = 1'b0;
    n.acu_strobe = 1'b0;
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
    // three-stage input sampling, a change counts once stages two and three agree
    n.s1 = {acu_abandoned, acu_connected, adapter_check, rx_data, line_clk};
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < 5; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.flt[i] = r.s3[i];
      end
    end
    lrise = n.flt[0] & ~r.flt[0];
    lfall = ~n.flt[0] & r.flt[0];
    din = r.test ? r.txd : r.flt[1];
    nsh = {din, r.rsh[7:1]};

    // bus data phase writes
    if (r.ap_v && r.ap_wr) begin
      case (r.ap_addr)
        `BLAF_OFS_START: begin
          ctl = hwdata[7:0];
          nc = hwdata[10:8];
          if (hwdata[31:24] == `BLAF_OPCODE && hwdata[23:20] == `BLAF_DEVICE &&
              (!r.busy || r.st == blaf_pkg::st_wait || nc == `BLAF_N_CONTROL)) begin // see [R22]
            if (ctl[`BLAF_CB_RESET_IRQ]) begin
              n.pending = 1'b0;
            end
            if (ctl[`BLAF_CB_ACTIVATE]) begin
              n.int_en = ctl[`BLAF_CB_INT_EN];
              if (ctl[`BLAF_CB_TIMED] && nc == `BLAF_N_CONTROL) begin
                n.st = blaf_pkg::st_wait;
                n.busy = 1'b1;
                n.tmr = 28'h0;
              end else if (!ctl[`BLAF_CB_TIMED] && r.st == blaf_pkg::st_wait) begin
                n.st = blaf_pkg::st_idle;
                n.busy = 1'b0;
              end
            end
            n.step = ctl[`BLAF_CB_STEP];
            n.test = ctl[`BLAF_CB_TEST];
            n.enabled = ctl[`BLAF_CB_ENABLE];
            if (!ctl[`BLAF_CB_ENABLE]) begin
              n.op_end = 1'b0; // see [R12]
              n.itb = 1'b0;
            end
            if (nc != `BLAF_N_CONTROL && ctl[`BLAF_CB_ENABLE] && !r.busy) begin
              n.busy = 1'b1;
              n.tmo = 1'b0;
              n.chk_err = 1'b0;
              n.bc_on = 1'b0;
              n.xpar = 1'b0;
              n.prev_dle = 1'b0;
              n.chk_n = 2'h0;
              n.pad_keep = 1'b0;
              n.end_rx = 1'b0;
              n.tmr = 28'h0;
              n.rsync = 2'h0;
              case (nc)
                `BLAF_N_RECEIVE, `BLAF_N_RXINIT: n.st = blaf_pkg::st_rx;
                `BLAF_N_TXRX: begin
                  n.st = blaf_pkg::st_tx;
                  if (r.internal) begin
                    n.q = {8'h00, `BLAF_SYN, `BLAF_SYN, `BLAF_PAD_55, `BLAF_PAD_55,
                           `BLAF_PAD_55}; // see [R6]
                    n.qn = 3'h5;
                  end else begin
                    n.q = {24'h0, `BLAF_SYN, `BLAF_SYN, `BLAF_PAD_55}; // see [R3] [R5]
                    n.qn = 3'h3;
                  end
                end
                `BLAF_N_AUTOCALL: n.st = blaf_pkg::st_acu;
                `BLAF_N_LOOP: n.st = blaf_pkg::st_loop;
                default: n.busy = 1'b0;
              endcase
            end
          end
        end
        `BLAF_OFS_CUR: n.current_address = hwdata[15:0];
        `BLAF_OFS_TRANS: n.transition_address = hwdata[15:0];
        `BLAF_OFS_STOP: n.stop_address = hwdata[15:0];
        `BLAF_OFS_CFG: begin
          n.ascii = hwdata[`BLAF_CFG_ASCII];
          n.internal = hwdata[`BLAF_CFG_INTERNAL];
          n.slave = hwdata[`BLAF_CFG_SLAVE];
        end
        default: ;
      endcase
    end

    // bus address phase, reads answer in the following data phase
    n.ap_v = hsel & hready & htrans[1];
    if (n.ap_v) begin
      n.ap_wr = hwrite;
      n.ap_addr = haddr[7:0];
      n.hrdata = 32'h0;
      if (!hwrite) begin
        case (haddr[7:0])
          `BLAF_OFS_CUR: n.hrdata[15:0] = r.current_address;
          `BLAF_OFS_TRANS: n.hrdata[15:0] = r.transition_address;
          `BLAF_OFS_STOP: n.hrdata[15:0] = r.stop_address;
          `BLAF_OFS_CFG: begin
            n.hrdata[`BLAF_CFG_ASCII] = r.ascii;
            n.hrdata[`BLAF_CFG_INTERNAL] = r.internal;
            n.hrdata[`BLAF_CFG_SLAVE] = r.slave;
          end
          `BLAF_OFS_STATUS: begin
            n.hrdata[`BLAF_ST_BUSY] = r.busy;
            n.hrdata[`BLAF_ST_ENABLED] = r.enabled;
            n.hrdata[`BLAF_ST_INT_EN] = r.int_en;
            n.hrdata[`BLAF_ST_PENDING] = r.pending;
            n.hrdata[`BLAF_ST_OPEND] = r.op_end;
            n.hrdata[`BLAF_ST_ITB] = r.itb;
            n.hrdata[`BLAF_ST_TMO] = r.tmo;
            n.hrdata[`BLAF_ST_CHKERR] = r.chk_err;
            n.hrdata[`BLAF_ST_SYNC] = (r.rsync == 2'h2);
            n.hrdata[`BLAF_ST_STEP] = r.step;
            n.hrdata[`BLAF_ST_TEST] = r.test;
          end
          `BLAF_OFS_TEST_OPEND: begin
            n.hrdata[0] = r.op_end;
            n.op_end = 1'b0; // see [R12]
          end
          `BLAF_OFS_TEST_ITB: begin
            n.hrdata[0] = r.itb;
            n.itb = 1'b0; // see [R12]
          end
          default: ;
        endcase
      end
    end

    // transmit shifter, lsb first, marks only while no character is loaded or queued
    if (lfall) begin
      if (r.tcnt != 4'h0) begin
        n.txd = r.tsh[0];
        n.tsh = {1'b0, r.tsh[7:1]};
        n.tcnt = r.tcnt - 4'h1;
      end else begin
        n.txd = 1'b1;
      end
    end
    if (r.tcnt == 4'h0 && r.qn != 3'h0) begin
      n.tsh = r.q[0];
      n.tcnt = 4'h8;
      n.q = {8'h00, r.q[5:1]};
      n.qn = r.qn - 3'h1;
    end

    // framing of one character, shared by both directions
    b = (r.st == blaf_pkg::st_tx) ? mem_rdata : r.rbyte;
    blk = (b == `BLAF_ETB || b == `BLAF_ETX || b == `BLAF_ITB);
    cod = (b == `BLAF_EOT || b == `BLAF_NAK || b == `BLAF_ENQ);
    c_bc = r.bc;
    c_on = r.bc_on;
    c_xpar = r.xpar;
    if (b == `BLAF_SOH || b == `BLAF_STX) begin
      c_bc = 16'h0;
      c_on = 1'b1;
      c_xpar = r.xpar | (r.prev_dle && b == `BLAF_STX);
    end else if (r.bc_on && b != `BLAF_SYN && !(r.xpar && b == `BLAF_DLE && !r.prev_dle)) begin
      c_bc = bc_upd(r.bc, b, r.ascii); // see [R9]
    end
    if (blk && r.prev_dle) begin
      c_xpar = 1'b0;
    end

    unique case (r.st)
      blaf_pkg::st_idle: ;
      blaf_pkg::st_wait: begin
        n.tmr = r.tmr + 28'h1;
        fin = (r.tmr == 28'(WAIT_CYC - 1)); // see [R14]
      end
      blaf_pkg::st_tx: begin
        n.tmr = r.tmr + 28'h1;
        if (n.flt[2]) begin
          n.qn = 3'h0; // see [R18]
          n.tcnt = 4'h0;
          fin = 1'b1;
        end else if (r.mem_req && mem_ack) begin
          n.mem_req = 1'b0;
          n.current_address = r.current_address + 16'h1; // see [R23]
          n.tsh = b;
          n.tcnt = 4'h8;
          n.prev_dle = (b == `BLAF_DLE) && !r.prev_dle;
          n.bc = c_bc;
          n.bc_on = c_on;
          n.xpar = c_xpar;
          if (blk) begin
            n.bc = 16'h0;
            n.bc_on = (b == `BLAF_ITB);
            if (r.ascii) begin
              n.q[0] = c_bc[7:0];
              n.q[1] = (b == `BLAF_ITB) ? `BLAF_SYN : `BLAF_PAD_FF; // see [R1] [R8]
              n.q[2] = `BLAF_SYN;
              n.qn = (b == `BLAF_ITB) ? 3'h3 : 3'h2;
            end else begin
              n.q[0] = c_bc[15:8];
              n.q[1] = c_bc[7:0];
              n.q[2] = (b == `BLAF_ITB) ? `BLAF_SYN : `BLAF_PAD_FF; // see [R1] [R8]
              n.q[3] = `BLAF_SYN;
              n.qn = (b == `BLAF_ITB) ? 3'h4 : 3'h3;
            end
          end else if (cod) begin
            n.q[0] = `BLAF_PAD_FF; // see [R1] [R2]
            n.qn = 3'h1;
            n.bc_on = 1'b0;
          end
        end else if (!r.mem_req && r.tcnt == 4'h0 && r.qn == 3'h0) begin
          if (r.tmr >= 28'(TX_FILL_CYC - 1)) begin
            n.tmr = 28'h0;
            n.q[0] = r.xpar ? `BLAF_DLE : `BLAF_SYN; // see [R7]
            n.q[1] = `BLAF_SYN;
            n.qn = 3'h2;
          end else if (r.current_address == r.transition_address) begin
            if (r.transition_address == r.stop_address) begin
              fin = 1'b1; // see [R17]
            end else begin
              n.st = blaf_pkg::st_rx;
              n.rsync = 2'h0;
              n.tmr = 28'h0;
              n.bc_on = 1'b0;
            end
          end else begin
            n.mem_req = 1'b1;
            n.mem_we = 1'b0;
            n.mem_addr = r.current_address;
          end
        end
      end
      blaf_pkg::st_rx: begin
        n.tmr = r.tmr + 28'h1;
        if (lrise) begin
          n.rsh = nsh;
          n.rcnt = r.rcnt + 3'h1;
          if (r.rsync == 2'h0) begin
            if (nsh == `BLAF_SYN) begin
              n.rsync = 2'h1;
              n.rcnt = 3'h0;
            end
          end else if (r.rcnt == 3'h7) begin
            if (r.rsync == 2'h2) begin
              n.rb = 1'b1;
              n.rbyte = nsh;
            end else begin
              n.rsync = (nsh == `BLAF_SYN) ? 2'h2 : 2'h0; // see [R5]
            end
          end
        end
        if (r.mem_req && mem_ack) begin
          n.mem_req = 1'b0;
          n.current_address = r.current_address + 16'h1; // see [R23]
          fin = r.end_rx || (r.current_address + 16'h1 == r.stop_address); // see [R16]
        end else if (r.tmr == 28'(RX_TMO_CYC - 1) && !r.mem_req) begin
          n.tmo = 1'b1; // see [R16]
          fin = 1'b1;
        end
        if (r.rb) begin
          if (r.chk_n != 2'h0) begin
            mism = (r.chk_n == 2'h2) ? (b != r.expc[15:8]) : (b != r.expc[7:0]); // see [R10]
            n.chk_err = r.chk_err | mism;
            n.chk_n = r.chk_n - 2'h1;
            if (r.chk_n == 2'h1) begin
              if (r.chk_itb) begin
                n.itb = n.itb | (r.slave && !r.chk_err && !mism); // see [R20] [R21]
              end else if (r.mem_req) begin
                n.end_rx = 1'b1;
              end else begin
                fin = 1'b1; // see [R16]
              end
            end
          end else if (b == `BLAF_SYN) begin
            n.tmr = 28'h0; // see [R10]
          end else if (!r.pad_keep && !r.bc_on && (b == `BLAF_PAD_55 || b == `BLAF_PAD_FF)) begin
            n.tmr = n.tmr; // see [R4]
          end else begin
            n.mem_req = 1'b1; // see [R11] [R4]
            n.mem_we = 1'b1;
            n.mem_addr = r.current_address;
            n.mem_wdata = b;
            n.end_rx = r.pad_keep || b == `BLAF_ENQ;
            n.pad_keep = (b == `BLAF_EOT || b == `BLAF_NAK);
            n.prev_dle = (b == `BLAF_DLE) && !r.prev_dle;
            n.bc = c_bc;
            n.bc_on = c_on;
            n.xpar = c_xpar;
            if (blk) begin
              n.expc = c_bc;
              n.chk_n = r.ascii ? 2'h1 : 2'h2;
              n.chk_itb = (b == `BLAF_ITB);
              n.bc = 16'h0;
              n.bc_on = (b == `BLAF_ITB);
            end
          end
        end
      end
      blaf_pkg::st_acu: begin
        if (r.mem_req && mem_ack) begin
          n.mem_req = 1'b0;
          n.current_address = r.current_address + 16'h1; // see [R23]
          n.acu_digit = mem_rdata[3:0];
          n.acu_strobe = 1'b1;
        end else if (!r.mem_req) begin
          if (r.current_address == r.stop_address) begin
            n.st = blaf_pkg::st_acu_wait;
          end else begin
            n.mem_req = 1'b1;
            n.mem_we = 1'b0;
            n.mem_addr = r.current_address;
          end
        end
      end
      blaf_pkg::st_acu_wait: begin
        n.tmo = r.flt[4] & ~r.flt[3];
        fin = r.flt[3] | r.flt[4]; // see [R15]
      end
      blaf_pkg::st_loop: begin
        if (r.mem_req && mem_ack) begin
          n.mem_req = 1'b0;
          n.current_address = r.current_address + 16'h1; // see [R23]
        end else if (!r.mem_req) begin
          if (r.current_address == r.stop_address) begin
            fin = 1'b1; // see [R19]
          end else begin
            n.mem_req = 1'b1;
            n.mem_we = 1'b0;
            n.mem_addr = r.current_address;
          end
        end
      end
    endcase
    if (fin) begin
      n.op_end = 1'b1; // see [R14]
      n.busy = 1'b0;
      n.mem_req = 1'b0;
      n.st = blaf_pkg::st_idle;
    end
    if ((n.op_end & ~r.op_end) | (n.itb & ~r.itb)) begin
      n.pending = 1'b1; // see [R13]
    end
    n.irq = n.pending & n.int_en; // see [R13]
    next_r = n;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.hreadyout <= 1'b1;
      r.txd <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = r.hresp;
  assign mem_req = r.mem_req;
  assign mem_we = r.mem_we;
  assign mem_addr = r.mem_addr;
  assign mem_wdata = r.mem_wdata;
  assign tx_data = r.txd;
  assign acu_digit = r.acu_digit;
  assign acu_strobe = r.acu_strobe;
  assign irq = r.irq;

  logic n_chk;
  assign n_chk = r.s2[2] == r.s3[2] && r.s3[2];

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_pad_after_eot: assert property ( // see [R2]
    (r.st == blaf_pkg::st_tx && r.mem_req && mem_ack && !n_chk && mem_rdata == `BLAF_EOT)
    |=> (r.q[0] == `BLAF_PAD_FF && r.qn == 3'h1 && r.tsh == `BLAF_EOT))
    else $error("no pad queued after eot");
  a_pad_after_check: assert property ( // see [R1]
    (r.st == blaf_pkg::st_tx && r.mem_req && mem_ack && !n_chk && !r.ascii &&
     mem_rdata == `BLAF_ETX) |=> (r.qn == 3'h3 && r.q[2] == `BLAF_PAD_FF))
    else $error("pad does not follow block check");
  a_lead_pad: assert property ( // see [R3]
    $rose(r.st == blaf_pkg::st_tx) |-> (r.q[0] == `BLAF_PAD_55 &&
      r.qn == (r.internal ? 3'h5 : 3'h3) && r.q[r.qn - 3'h1] == `BLAF_SYN))
    else $error("transmission preamble wrong");
  a_two_syn: assert property ( // see [R5]
    $rose(r.rsync == 2'h2) |-> ($past(r.rsync) == 2'h1 && r.rsh == `BLAF_SYN))
    else $error("sync declared without two syn");
  a_itb_syn: assert property ( // see [R8]
    (r.st == blaf_pkg::st_tx && r.mem_req && mem_ack && !n_chk && mem_rdata == `BLAF_ITB)
    |=> (r.q[r.qn - 3'h1] == `BLAF_SYN && r.q[r.qn - 3'h2] == `BLAF_SYN))
    else $error("syn syn missing after block check");
  a_irq_masked: assert property ( // see [R13]
    (!r.int_en && !(r.ap_v && r.ap_wr)) |=> !r.irq)
    else $error("request raised while interrupts disabled");
  a_car_step: assert property ( // see [R23]
    (r.mem_req && mem_ack && r.st != blaf_pkg::st_idle && !(r.ap_v && r.ap_wr))
    |=> (r.current_address == $past(r.current_address) + 16'h1 && !r.mem_req))
    else $error("current address did not step by one");
  a_tx_end: assert property ( // see [R17]
    (r.st == blaf_pkg::st_tx && !r.mem_req && r.tcnt == 4'h0 && r.qn == 3'h0 && !n_chk &&
     r.current_address == r.transition_address && r.transition_address == r.stop_address && r.tmr < 28'(TX_FILL_CYC - 1))
    |=> (r.op_end && r.st == blaf_pkg::st_idle && !r.busy))
    else $error("transmit did not end on equal addresses");
  a_check_abort: assert property ( // see [R18]
    (r.st == blaf_pkg::st_tx && r.flt[2] && r.s2[2] == r.s3[2]) |=> (r.op_end && r.qn == 3'h0))
    else $error("adapter check did not end transmit");
  a_pend_follows: assert property ( // see [R13]
    $rose(r.op_end) |-> r.pending ##1 (r.irq == r.int_en))
    else $error("pending not set by latch");

  c_tx_done: cover property ($fell(r.busy) && r.op_end && $past(r.st) == blaf_pkg::st_tx);
  c_rx_sync: cover property ($rose(r.rsync == 2'h2));
  c_itb: cover property ($rose(r.itb));
  c_wait_done: cover property ($past(r.st) == blaf_pkg::st_wait && r.op_end);
endmodule

// file: blaf_defs.svh
`ifndef BLAF_DEFS_SVH
`define BLAF_DEFS_SVH
// register byte offsets
`define BLAF_OFS_START 8'h00
`define BLAF_OFS_CUR 8'h04
`define BLAF_OFS_TRANS 8'h08
`define BLAF_OFS_STOP 8'h0c
`define BLAF_OFS_CFG 8'h10
`define BLAF_OFS_STATUS 8'h14
`define BLAF_OFS_TEST_OPEND 8'h18
`define BLAF_OFS_TEST_ITB 8'h1c
// start command word: opcode, device field, function code, control byte
`define BLAF_OPCODE 8'hf3
`define BLAF_DEVICE 4'h8
`define BLAF_N_CONTROL 3'h0
`define BLAF_N_RECEIVE 3'h1
`define BLAF_N_TXRX 3'h2
`define BLAF_N_RXINIT 3'h3
`define BLAF_N_AUTOCALL 3'h4
`define BLAF_N_LOOP 3'h6
// control byte positions, byte bit 0 is the lsb
`define BLAF_CB_RESET_IRQ 7
`define BLAF_CB_INT_EN 6
`define BLAF_CB_TIMED 5
`define BLAF_CB_STEP 3
`define BLAF_CB_TEST 2
`define BLAF_CB_ENABLE 1
`define BLAF_CB_ACTIVATE 0
// config fields
`define BLAF_CFG_ASCII 0
`define BLAF_CFG_INTERNAL 1
`define BLAF_CFG_SLAVE 2
// status fields
`define BLAF_ST_BUSY 0
`define BLAF_ST_ENABLED 1
`define BLAF_ST_INT_EN 2
`define BLAF_ST_PENDING 3
`define BLAF_ST_OPEND 4
`define BLAF_ST_ITB 5
`define BLAF_ST_TMO 6
`define BLAF_ST_CHKERR 7
`define BLAF_ST_SYNC 8
`define BLAF_ST_STEP 9
`define BLAF_ST_TEST 10
// line characters
`define BLAF_PAD_FF 8'hff
`define BLAF_PAD_55 8'h55
`define BLAF_SYN 8'h32
`define BLAF_SOH 8'h01
`define BLAF_STX 8'h02
`define BLAF_ETB 8'h26
`define BLAF_ETX 8'h03
`define BLAF_EOT 8'h37
`define BLAF_ENQ 8'h2d
`define BLAF_NAK 8'h3d
`define BLAF_DLE 8'h10
`define BLAF_ITB 8'h1f
`define BLAF_CRC_POLY 16'ha001
// timing
`define BLAF_CLK_HZ 50000000
`define BLAF_TX_FILL_MS 1000
`define BLAF_WAIT_MS 2000
`define BLAF_RX_TMO_MS 3000
`endif

// file: blaf_pkg.sv
package blaf_pkg;
  typedef enum logic [2:0] {
    st_idle, st_tx, st_rx, st_acu, st_acu_wait, st_loop, st_wait
  } blaf_phase_type;

  typedef struct packed {
    blaf_phase_type st;
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] flt;
    logic [15:0] current_address;
    logic [15:0] transition_address;
    logic [15:0] stop_address;
    logic ascii;
    logic internal;
    logic slave;
    logic int_en;
    logic step;
    logic test;
    logic enabled;
    logic op_end;
    logic itb;
    logic pending;
    logic irq;
    logic tmo;
    logic chk_err;
    logic busy;
    logic [27:0] tmr;
    logic [7:0] tsh;
    logic [3:0] tcnt;
    logic txd;
    logic [5:0][7:0] q;
    logic [2:0] qn;
    logic [7:0] rsh;
    logic [2:0] rcnt;
    logic [1:0] rsync;
    logic rb;
    logic [7:0] rbyte;
    logic [15:0] bc;
    logic [15:0] expc;
    logic bc_on;
    logic xpar;
    logic prev_dle;
    logic [1:0] chk_n;
    logic chk_itb;
    logic pad_keep;
    logic end_rx;
    logic mem_req;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [3:0] acu_digit;
    logic acu_strobe;
    logic ap_v;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } blaf_regs_type;
endpackage

// file: blaf_modem_model.sv
`include "blaf_defs.svh"
module blaf_modem_model (
  // synchronous line
  output logic line_clk,
  output logic rx_data,
  input wire logic tx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] sr;
  logic synced;
  logic [7:0] pre;
  logic [7:0] txq[$];
  int nb;
  // modem bit clock runs free, line rests at mark
  initial begin
    sr = '1;
    synced = 1'b0;
    line_clk = 1'b0;
    rx_data = 1'b1;
    forever #80 line_clk = ~line_clk;
  end
  always @(posedge line_clk) begin
    sr = {tx_data, sr[23:1]};
    nb = nb + 1;
    if (!synced && sr[23:8] == {`BLAF_SYN, `BLAF_SYN}) begin
      synced = 1'b1;
      pre = sr[7:0];
      nb = 0;
    end else if (synced && nb == 8) begin
      txq.push_back(sr[23:16]);
      nb = 0;
    end
  end
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge line_clk);
      rx_data <= b[i];
    end
  endtask
endmodule

// file: tb_top.sv
`include "blaf_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic mem_req, mem_we, mem_ack, line_clk, rx_data, tx_data, adapter_check;
  logic acu_connected, acu_abandoned;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [7:0] mem [256];
  logic [7:0] wq[$];
  int err_count, total_checks, cyc;
  blaf_line_adapter #(.TX_FILL_CYC(2000), .WAIT_CYC(2000), .RX_TMO_CYC(2000)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .line_clk(line_clk), .rx_data(rx_data), .adapter_check(adapter_check), .tx_data(tx_data),
    .acu_digit(), .acu_strobe(), .acu_connected(acu_connected),
    .acu_abandoned(acu_abandoned), .irq(irq));
  blaf_modem_model u_modem (.line_clk(line_clk), .rx_data(rx_data), .tx_data(tx_data));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // host storage answers each cycle steal one cycle later
  always @(posedge hclk) begin
    mem_ack <= 1'b0;
    cyc <= cyc + 1;
    if (mem_req === 1'b1 && mem_ack !== 1'b1) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[7:0]];
      if (mem_we) wq.push_back(mem_wdata);
    end
    if (cyc == 40000) begin
      err_count++;
      print_verdict;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic [31:0] sw(input logic [2:0] n, input logic [7:0] cb);
    return {`BLAF_OPCODE, `BLAF_DEVICE, 9'h0, n, cb};
  endfunction
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge hclk);
  endtask
  task automatic t_regs;
    ahb(1, `BLAF_OFS_CUR, 32'h1234);
    ahb(0, `BLAF_OFS_CUR, 0);
    chk(rd, 32'h1234, "current address");
    ahb(1, 8'h40, 32'hffff);
    ahb(0, 8'h40, 0);
    chk(rd, 0, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_wait;
    ahb(1, `BLAF_OFS_START, sw(`BLAF_N_CONTROL, 8'h21));
    repeat (1900) @(posedge hclk);
    ahb(0, `BLAF_OFS_STATUS, 0);
    chk(rd[`BLAF_ST_OPEND], 0, "wait early");
    repeat (200) @(posedge hclk);
    chk(irq, 0, "irq while disabled");
    ahb(0, `BLAF_OFS_STATUS, 0);
    chk(rd[`BLAF_ST_PENDING], 1, "pending");
    ahb(1, `BLAF_OFS_START, sw(`BLAF_N_CONTROL, 8'h43));
    repeat (2) @(posedge hclk);
    chk(irq, 1, "irq after enable");
    ahb(0, `BLAF_OFS_TEST_OPEND, 0);
    chk(rd, 1, "op-end latch");
    ahb(0, `BLAF_OFS_TEST_OPEND, 0);
    chk(rd, 0, "latch cleared");
    chk(irq, 1, "pending sticky");
    ahb(1, `BLAF_OFS_START, sw(`BLAF_N_CONTROL, 8'h80));
    repeat (2) @(posedge hclk);
    chk(irq, 0, "pending reset");
    $display("test wait done");
  endtask
  task automatic t_tx;
    mem[0] = `BLAF_STX;
    mem[1] = 8'h41;
    mem[2] = `BLAF_ETX;
    ahb(1, `BLAF_OFS_CUR, 0);
    ahb(1, `BLAF_OFS_TRANS, 3);
    ahb(1, `BLAF_OFS_STOP, 3);
    ahb(1, `BLAF_OFS_CFG, 0);
    u_modem.synced = 1'b0;
    ahb(1, `BLAF_OFS_START, sw(`BLAF_N_TXRX, 8'h02));
    wait_irq(20000);
    chk(irq, 1, "tx op end");
    ahb(0, `BLAF_OFS_CUR, 0);
    chk(rd, 3, "tx current address");
    repeat (300) @(posedge hclk);
    chk(u_modem.pre, `BLAF_PAD_55, "lead pad");
    for (int i = 0; i < 3; i++) chk(u_modem.txq[i], mem[i], "tx byte");
    chk(u_modem.txq[5], `BLAF_PAD_FF, "trail pad");
    ahb(0, `BLAF_OFS_TEST_OPEND, 0);
    ahb(1, `BLAF_OFS_START, sw(`BLAF_N_CONTROL, 8'h80));
    $display("test tx done");
  endtask
  task automatic t_rx;
    logic [7:0] f[8] = '{8'h55, `BLAF_SYN, `BLAF_SYN, `BLAF_DLE, 8'h70, 8'h41, `BLAF_NAK, 8'hff};
    ahb(1, `BLAF_OFS_CUR, 16'h10);
    ahb(1, `BLAF_OFS_STOP, 16'h20);
    ahb(1, `BLAF_OFS_START, sw(`BLAF_N_RECEIVE, 8'h02));
    for (int i = 0; i < 8; i++) u_modem.send(f[i]);
    wait_irq(3000);
    chk(irq, 1, "rx op end");
    for (int i = 0; i < 5; i++) chk(wq[i], f[i + 3], "stored byte");
    ahb(0, `BLAF_OFS_CUR, 0);
    chk(rd, 16'h15, "rx current address");
    $display("test rx done");
  endtask
  task automatic t_chk;
    ahb(1, `BLAF_OFS_CUR, 0);
    ahb(1, `BLAF_OFS_START, sw(`BLAF_N_TXRX, 8'h02));
    adapter_check <= 1'b1;
    wait_irq(100);
    chk(irq, 1, "check ends tx");
    ahb(0, `BLAF_OFS_STATUS, 0);
    chk(rd[`BLAF_ST_BUSY], 0, "tx aborted");
    adapter_check <= 1'b0;
    ahb(1, `BLAF_OFS_START, sw(`BLAF_N_CONTROL, 8'h80));
    $display("test check done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    mem_ack = 1'b0;
    mem_rdata = 8'h0;
    adapter_check = 1'b0;
    acu_connected = 1'b0;
    acu_abandoned = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_wait;
    t_tx;
    t_chk;
    t_rx;
    print_verdict;
  end
endmodule
